/* File: src/fpc_flash_regs.vh */
// constants for the flash program control block
// assumes a 25 MHz core clock and an 8-bit special-function register space
`ifndef FPC_FLASH_REGS_VH
`define FPC_FLASH_REGS_VH

// control register location and layout
`define FPC_CTRL_ADDR 8'hD1
`define FPC_CTRL_RESET 8'h00
`define FPC_KEY_HI 7
`define FPC_KEY_LO 4
`define FPC_MAP_BIT 3
`define FPC_MODE_HI 2
`define FPC_MODE_LO 1
`define FPC_BUSY_BIT 0

// launch codes in the key field
`define FPC_KEY_FIRST 4'h5
`define FPC_KEY_SECOND 4'hA

// target space select codes
`define FPC_MODE_USER 2'b00
`define FPC_MODE_XROW 2'b01
`define FPC_MODE_SEC 2'b10
`define FPC_MODE_RSVD 2'b11

// security byte layout and shipped default
`define FPC_SEC_DEFAULT 8'hB0
`define FPC_SEC_SPEED_BIT 7
`define FPC_SEC_BOOT_BIT 6
`define FPC_SEC_OSC_HI 5
`define FPC_SEC_OSC_LO 4
`define FPC_SEC_RSVD_BIT 3
`define FPC_SEC_LOCK_HI 2
`define FPC_SEC_LOCK_LO 0
`define FPC_OSC_32MHZ 2'b11
`define FPC_OSC_16MHZ 2'b10
`define FPC_OSC_8MHZ 2'b01
`define FPC_OSC_FORBID 2'b00

// memory geometry
`define FPC_PAGE_BYTES 128
`define FPC_PAGE_BITS 7
`define FPC_PAGE_COUNT 256
`define FPC_PAGE_SEL_BITS 8
`define FPC_USER_BYTES 32768
`define FPC_USER_TOP 16'h7FFF
`define FPC_XROW_BASE 16'hFF80
`define FPC_ERASED 8'hFF

// boot entry points
`define FPC_BOOT_APP 16'h0000
`define FPC_BOOT_LOADER 16'hF400

// programming time
`define FPC_PROG_TIME_US 10000
`define FPC_CLK_MHZ 25
`define FPC_PROG_CYCLES (`FPC_PROG_TIME_US * `FPC_CLK_MHZ)

`endif

/* File: src/fpc_sync2.v */
// two-stage synchroniser for one asynchronous level
// assumes the level is slow compared with the core clock
`timescale 1ns/1ps

module fpc_sync2 (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire async_in,
	output reg sync_out
);

	reg stage1;

	// resets high: the external access pin idles high (internal fetch)
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= 1'b1;
			sync_out <= 1'b1;
		end else if (ce) begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

/* File: src/fpc_flash_array.v */
// flash storage: user array, extra row, security byte and column latches
// assumes the controller never loads latches or reads while programming
`timescale 1ns/1ps
`include "fpc_flash_regs.vh"

module fpc_flash_array (
	input wire clk,
	input wire rst,
	input wire por,
	input wire ce,
	input wire latch_wr,
	input wire [15:0] latch_addr,
	input wire [7:0] latch_wdata,
	input wire erase,
	input wire prog_strobe,
	input wire [1:0] target_mode,
	input wire [1:0] rd_mode,
	input wire [15:0] rd_addr,
	output reg [7:0] rd_data,
	output wire [7:0] security
);

	reg [7:0] user_mem [0:`FPC_USER_BYTES-1];
	reg [7:0] xrow_mem [0:`FPC_PAGE_BYTES-1];
	reg [7:0] col_latch [0:`FPC_PAGE_BYTES-1];
	reg [`FPC_PAGE_BYTES-1:0] loaded;
	reg [`FPC_PAGE_SEL_BITS-1:0] page_sel;
	reg [7:0] sec_byte;
	integer i;

	assign security = sec_byte;

	// the last page address loaded selects the page to program
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			loaded <= {`FPC_PAGE_BYTES{1'b0}};
			page_sel <= {`FPC_PAGE_SEL_BITS{1'b0}};
		end else if (ce) begin
			// a load in the strobe cycle belongs to the next run, so it
			// must survive the clear
			if (prog_strobe) begin
				loaded <= {`FPC_PAGE_BYTES{1'b0}};
			end
			if (latch_wr) begin
				loaded[latch_addr[`FPC_PAGE_BITS-1:0]] <= 1'b1;
				page_sel <= latch_addr[14:`FPC_PAGE_BITS];
			end
		end
	end

	always @(posedge clk) begin
		if (ce && latch_wr) begin
			col_latch[latch_addr[`FPC_PAGE_BITS-1:0]] <= latch_wdata;
		end
	end

	// only loaded bytes are erased, then programmed; others keep their data
	always @(posedge clk) begin
		if (ce && (erase || prog_strobe)) begin
			for (i = 0; i < `FPC_PAGE_BYTES; i = i + 1) begin
				if (loaded[i]) begin
					if (target_mode == `FPC_MODE_USER) begin
						user_mem[{page_sel, i[`FPC_PAGE_BITS-1:0]}] <=
							erase ? `FPC_ERASED : col_latch[i];
					end else if (target_mode == `FPC_MODE_XROW) begin
						xrow_mem[i] <= erase ? `FPC_ERASED : col_latch[i];
					end
				end
			end
		end
	end

	// security byte is non-volatile: only power-on restores the default;
	// software reaches the upper nibble alone, lock bits stay untouched
	always @(posedge clk or posedge por) begin
		if (por) begin
			sec_byte <= `FPC_SEC_DEFAULT;
		end else if (ce && target_mode == `FPC_MODE_SEC && loaded[0]) begin
			if (erase) begin
				sec_byte[7:4] <= 4'hF;
			end else if (prog_strobe) begin
				sec_byte[`FPC_SEC_SPEED_BIT] <=
					col_latch[0][`FPC_SEC_SPEED_BIT];
				sec_byte[`FPC_SEC_BOOT_BIT] <=
					col_latch[0][`FPC_SEC_BOOT_BIT];
				// the forbidden oscillator code is refused, erased value stays
				if (col_latch[0][`FPC_SEC_OSC_HI:`FPC_SEC_OSC_LO] !=
						`FPC_OSC_FORBID) begin
					sec_byte[`FPC_SEC_OSC_HI:`FPC_SEC_OSC_LO] <=
						col_latch[0][`FPC_SEC_OSC_HI:`FPC_SEC_OSC_LO];
				end
			end
		end
	end

	// combinational read; the controller registers it, so no wait state
	always @* begin
		rd_data = `FPC_ERASED;
		case (rd_mode)
			`FPC_MODE_USER: begin
				if (rd_addr <= `FPC_USER_TOP) begin
					rd_data = user_mem[rd_addr[14:0]];
				end
			end
			`FPC_MODE_XROW: begin
				if (rd_addr >= `FPC_XROW_BASE) begin
					rd_data = xrow_mem[rd_addr[`FPC_PAGE_BITS-1:0]];
				end
			end
			`FPC_MODE_SEC: begin
				if (rd_addr == 16'h0000) begin
					rd_data = {sec_byte[7:4], 1'b0,
						sec_byte[`FPC_SEC_LOCK_HI:`FPC_SEC_LOCK_LO]};
				end
			end
			default: begin
				rd_data = `FPC_ERASED;
			end
		endcase
	end

endmodule

/* File: src/fpc_flash_ctrl.v */
// flash program control: control register, unlock, busy timing, fetch path
// assumes a CPU core issuing one-cycle SFR, data-write and fetch strobes
`timescale 1ns/1ps
`include "fpc_flash_regs.vh"

// Operation
// - launch needs key 5 written, then key A; mode field picks operation
// - map bit set sends data writes to column latches, clear restores RAM
// - mode 00 user, 01 extra row, 10 security byte, 11 no action
// - busy flag bit 0 is set while programming runs
// - only hardware clears busy at completion; software writes cannot
// - reset returns the whole control register to zero
// - user array is 256 pages of 128 bytes, low bits address byte
// - programming first erases loaded locations automatically
// - erase-and-program holds busy for about 10 ms
// - array reads return one byte per access with no wait state
// - core idles while busy and resumes when programming ends
// - external access pin low sends fetches to external program memory
// - security bit 7 clear gives double speed, set gives standard
// - security bit 6 set boots at 0000h, clear boots loader F400h
// - security bits 5-4 choose oscillator range, one code forbidden
// - security bits 2-0 are lock bits, shipped at level four
module fpc_flash_ctrl #(
	parameter PROG_CYCLES = `FPC_PROG_CYCLES
) (
	input wire clk,
	input wire rst,
	input wire por,
	input wire ce,
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	input wire xdata_wr,
	input wire [15:0] xdata_addr,
	input wire [7:0] xdata_wdata,
	output reg ram_wr,
	output reg [15:0] ram_addr,
	output reg [7:0] ram_wdata,
	input wire code_rd,
	input wire [15:0] code_addr,
	output reg [7:0] code_rdata,
	output reg code_valid,
	output reg code_external,
	input wire external_access_pin,
	output reg program_busy_flag,
	output reg core_idle,
	output reg double_speed_select,
	output reg boot_jump_select,
	output reg [15:0] boot_address,
	output reg [1:0] oscillator_range,
	output reg osc_range_forbidden,
	output reg [2:0] lock_level_bits
);

	localparam ST_IDLE = 3'b001;
	localparam ST_ARMED = 3'b010;
	localparam ST_BUSY = 3'b100;

	function ctrl_hit;
		input [7:0] addr;
		begin
			ctrl_hit = (addr == `FPC_CTRL_ADDR);
		end
	endfunction

	reg [2:0] state;
	reg [2:0] next_state;
	reg [3:0] launch_key_field;
	reg latch_space_map;
	reg [1:0] target_space_select;
	reg [1:0] run_mode;
	reg [17:0] prog_count;
	reg erase_pulse;
	reg program_pulse;
	reg boot_taken;
	reg launch;
	wire access_sync;
	wire [7:0] arr_rdata;
	wire [7:0] sec_byte;
	wire ctrl_wr;
	wire latch_wr;

	assign ctrl_wr = sfr_wr && ctrl_hit(sfr_addr);
	// latch loads are dropped while programming; the core is idle then
	assign latch_wr = xdata_wr && latch_space_map && !program_busy_flag;

	fpc_sync2 u_access_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.async_in(external_access_pin),
		.sync_out(access_sync)
	);

	fpc_flash_array u_array (
		.clk(clk),
		.rst(rst),
		.por(por),
		.ce(ce),
		.latch_wr(latch_wr),
		.latch_addr(xdata_addr),
		.latch_wdata(xdata_wdata),
		.erase(erase_pulse),
		.prog_strobe(program_pulse),
		.target_mode(run_mode),
		.rd_mode(target_space_select),
		.rd_addr(code_addr),
		.rd_data(arr_rdata),
		.security(sec_byte)
	);

	// unlock sequence; a launch while busy is ignored
	always @* begin
		next_state = state;
		launch = 1'b0;
		case (state)
			ST_IDLE: begin
				if (ctrl_wr &&
						sfr_wdata[`FPC_KEY_HI:`FPC_KEY_LO] == `FPC_KEY_FIRST) begin
					next_state = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (ctrl_wr) begin
					if (sfr_wdata[`FPC_KEY_HI:`FPC_KEY_LO] == `FPC_KEY_SECOND &&
							sfr_wdata[`FPC_MODE_HI:`FPC_MODE_LO] !=
							`FPC_MODE_RSVD) begin
						next_state = ST_BUSY;
						launch = 1'b1;
					end else if (sfr_wdata[`FPC_KEY_HI:`FPC_KEY_LO] ==
							`FPC_KEY_FIRST) begin
						next_state = ST_ARMED;
					end else begin
						next_state = ST_IDLE;
					end
				end
			end
			ST_BUSY: begin
				if (prog_count == 18'd1) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			launch_key_field <= 4'h0;
			latch_space_map <= 1'b0;
			target_space_select <= `FPC_MODE_USER;
			program_busy_flag <= 1'b0;
			run_mode <= `FPC_MODE_USER;
			prog_count <= 18'd0;
			erase_pulse <= 1'b0;
			program_pulse <= 1'b0;
			core_idle <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			erase_pulse <= launch;
			program_pulse <= 1'b0;
			if (ctrl_wr) begin
				launch_key_field <= sfr_wdata[`FPC_KEY_HI:`FPC_KEY_LO];
				latch_space_map <= sfr_wdata[`FPC_MAP_BIT];
				target_space_select <=
					sfr_wdata[`FPC_MODE_HI:`FPC_MODE_LO];
			end
			if (launch) begin
				program_busy_flag <= 1'b1;
				core_idle <= 1'b1;
				run_mode <= sfr_wdata[`FPC_MODE_HI:`FPC_MODE_LO];
				prog_count <= PROG_CYCLES[17:0];
			end else if (state == ST_BUSY) begin
				prog_count <= prog_count - 18'd1;
				if (prog_count == 18'd1) begin
					program_pulse <= 1'b1;
					program_busy_flag <= 1'b0;
					core_idle <= 1'b0;
				end
			end
		end
	end

	// register read shows live busy; writes never touch bit 0
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sfr_rdata <= `FPC_CTRL_RESET;
		end else if (ce) begin
			if (sfr_rd && ctrl_hit(sfr_addr)) begin
				sfr_rdata <= {launch_key_field, latch_space_map,
					target_space_select, program_busy_flag};
			end else begin
				sfr_rdata <= 8'h00;
			end
		end
	end

	// data writes pass to RAM only while the latch space is unmapped
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ram_wr <= 1'b0;
			ram_addr <= 16'h0000;
			ram_wdata <= 8'h00;
		end else if (ce) begin
			ram_wr <= xdata_wr && !latch_space_map;
			ram_addr <= xdata_addr;
			ram_wdata <= xdata_wdata;
		end
	end

	// fetch answers the cycle after the strobe, every time
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			code_rdata <= `FPC_ERASED;
			code_valid <= 1'b0;
			code_external <= 1'b0;
		end else if (ce) begin
			code_valid <= code_rd;
			code_external <= code_rd && !access_sync;
			if (!access_sync || program_busy_flag) begin
				code_rdata <= `FPC_ERASED;
			end else begin
				code_rdata <= arr_rdata;
			end
		end
	end

	// configuration outputs follow the non-volatile byte; boot entry is
	// caught once after reset so a change only acts on the next reset
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_taken <= 1'b0;
			boot_address <= `FPC_BOOT_LOADER;
			boot_jump_select <= 1'b0;
			double_speed_select <= 1'b0;
			oscillator_range <= `FPC_OSC_32MHZ;
			osc_range_forbidden <= 1'b0;
			lock_level_bits <= 3'b000;
		end else if (ce) begin
			if (!boot_taken) begin
				boot_taken <= 1'b1;
				boot_jump_select <= sec_byte[`FPC_SEC_BOOT_BIT];
				boot_address <= sec_byte[`FPC_SEC_BOOT_BIT] ?
					`FPC_BOOT_APP : `FPC_BOOT_LOADER;
			end
			double_speed_select <= !sec_byte[`FPC_SEC_SPEED_BIT];
			oscillator_range <=
				sec_byte[`FPC_SEC_OSC_HI:`FPC_SEC_OSC_LO];
			osc_range_forbidden <=
				sec_byte[`FPC_SEC_OSC_HI:`FPC_SEC_OSC_LO] ==
				`FPC_OSC_FORBID;
			lock_level_bits <=
				sec_byte[`FPC_SEC_LOCK_HI:`FPC_SEC_LOCK_LO];
		end
	end

endmodule

/* File: tb/fpc_cpu_model.sv */
// core-side model: one-cycle sfr, data-write and fetch strobes
// assumes the block samples strobes on the rising clock edge
`timescale 1ns/1ps
module fpc_cpu_model (
	input wire clk,
	output reg [7:0] sfr_addr,
	output reg sfr_wr,
	output reg sfr_rd,
	output reg [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata,
	output reg xdata_wr,
	output reg [15:0] xdata_addr,
	output reg [7:0] xdata_wdata,
	output reg code_rd,
	output reg [15:0] code_addr,
	input wire [7:0] code_rdata,
	input wire code_valid,
	input wire code_external
);
	initial begin
		{sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = 0;
		{xdata_wr, xdata_addr, xdata_wdata} = 0;
		{code_rd, code_addr} = 0;
	end
	// released lines flip so a stale value is never mistaken for data
	task wr(input [7:0] a, input [7:0] d);
	begin
		@(posedge clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
		sfr_addr <= ~a;
		sfr_wdata <= ~d;
	end
	endtask
	task rd(input [7:0] a, output [7:0] d);
	begin
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		sfr_addr <= ~a;
		@(posedge clk);
		d = sfr_rdata;
	end
	endtask
	task xw(input [15:0] a, input [7:0] d);
	begin
		@(posedge clk);
		xdata_addr <= a;
		xdata_wdata <= d;
		xdata_wr <= 1'b1;
		@(posedge clk);
		xdata_wr <= 1'b0;
		xdata_addr <= ~a;
		xdata_wdata <= ~d;
	end
	endtask
	task fetch(input [15:0] a, output [9:0] r);
	begin
		@(posedge clk);
		code_addr <= a;
		code_rd <= 1'b1;
		@(posedge clk);
		code_rd <= 1'b0;
		code_addr <= ~a;
		@(posedge clk);
		r = {code_external, code_valid, code_rdata};
	end
	endtask
	task launch(input [1:0] m);
	begin
		wr(8'hD1, {4'h5, 1'b0, m, 1'b0});
		wr(8'hD1, {4'hA, 1'b0, m, 1'b0});
	end
	endtask
endmodule

/* File: tb/fpc_flash_ctrl_checker.sv */
// concurrent checks on the flash control block ports
// assumes clock enable held high by the bench
`timescale 1ns/1ps
module fpc_flash_ctrl_checker #(
	parameter PROG_CYCLES = 20
) (
	input wire clk,
	input wire rst,
	input wire sfr_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_rdata,
	input wire xdata_wr,
	input wire [15:0] xdata_addr,
	input wire ram_wr,
	input wire [15:0] ram_addr,
	input wire code_rd,
	input wire [7:0] code_rdata,
	input wire code_valid,
	input wire code_external,
	input wire program_busy_flag,
	input wire core_idle,
	input wire [1:0] oscillator_range,
	input wire osc_range_forbidden
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	reg [31:0] bcnt;
	always @(posedge clk or posedge rst) begin
		if (rst)
			bcnt <= 0;
		else if (program_busy_flag)
			bcnt <= bcnt + 1;
		else
			bcnt <= 0;
	end
	property p_idle;
		core_idle == program_busy_flag;
	endproperty
	a_idle: assert property (p_idle) else $error("idle not busy");
	property p_launch;
		$rose(program_busy_flag) |-> $past(sfr_wr) || $past(sfr_wr, 2);
	endproperty
	a_launch: assert property (p_launch) else $error("busy w/o write");
	property p_len;
		$fell(program_busy_flag) |->
			bcnt >= PROG_CYCLES - 2 && bcnt <= PROG_CYCLES + 1;
	endproperty
	a_len: assert property (p_len) else $error("busy length");
	property p_nclr;
		program_busy_flag && sfr_wr && bcnt < PROG_CYCLES - 3
			|=> program_busy_flag;
	endproperty
	a_nclr: assert property (p_nclr) else $error("busy cleared");
	property p_rdbusy;
		sfr_rd && sfr_addr == 8'hD1 |=>
			sfr_rdata[0] == $past(program_busy_flag);
	endproperty
	a_rdbusy: assert property (p_rdbusy) else $error("busy bit");
	property p_ram;
		ram_wr |-> $past(xdata_wr) && ram_addr == $past(xdata_addr);
	endproperty
	a_ram: assert property (p_ram) else $error("ram write");
	property p_fetch;
		code_rd |=> code_valid;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch late");
	property p_ext;
		code_external |-> code_valid && code_rdata == 8'hFF;
	endproperty
	a_ext: assert property (p_ext) else $error("external fetch");
	property p_osc;
		osc_range_forbidden == (oscillator_range == 2'b00);
	endproperty
	a_osc: assert property (p_osc) else $error("osc flag");
	property p_rst;
		$fell(rst) |-> sfr_rdata == 8'h00 && !program_busy_flag;
	endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	c_launch: cover property ($rose(program_busy_flag));
	c_ram: cover property (ram_wr);
	c_ext: cover property (code_external);
endmodule
bind fpc_flash_ctrl fpc_flash_ctrl_checker #(
	.PROG_CYCLES(PROG_CYCLES)
) u_chk (
	.clk(clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata), .xdata_wr(xdata_wr),
	.xdata_addr(xdata_addr), .ram_wr(ram_wr), .ram_addr(ram_addr),
	.code_rd(code_rd), .code_rdata(code_rdata), .code_valid(code_valid),
	.code_external(code_external), .program_busy_flag(program_busy_flag),
	.core_idle(core_idle), .oscillator_range(oscillator_range),
	.osc_range_forbidden(osc_range_forbidden)
);

/* File: tb/tb_flash_program_control.sv */
// bench for the flash control block with a core-side model
// assumes a shortened programming time through PROG_CYCLES
`timescale 1ns/1ps
module tb_flash_program_control;
	localparam PC = 20;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg por = 1'b1;
	reg ext_pin_n = 1'b1;
	wire [7:0] sfr_addr, sfr_wdata, sfr_rdata, xdata_wdata, code_rdata;
	wire [7:0] ram_wdata;
	wire [15:0] xdata_addr, code_addr, ram_addr, boot;
	wire sfr_wr, sfr_rd, xdata_wr, code_rd, code_valid, code_external;
	wire ram_wr, busy, idle, dbl, bj, forb;
	wire [1:0] osc;
	wire [2:0] lock;
	integer num_errors = 0;
	integer num_checks = 0;
	integer nram = 0;
	integer n;
	reg [7:0] d;
	reg [9:0] r;
	reg [23:0] ram_last;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (ram_wr === 1'b1) begin
			nram = nram + 1;
			ram_last = {ram_addr, ram_wdata};
		end
	end
	fpc_cpu_model u_cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.xdata_wr(xdata_wr), .xdata_addr(xdata_addr),
		.xdata_wdata(xdata_wdata), .code_rd(code_rd), .code_addr(code_addr),
		.code_rdata(code_rdata), .code_valid(code_valid),
		.code_external(code_external));
	fpc_flash_ctrl #(.PROG_CYCLES(PC)) u_dut (.clk(clk), .rst(rst),
		.por(por), .ce(1'b1), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.xdata_wr(xdata_wr), .xdata_addr(xdata_addr),
		.xdata_wdata(xdata_wdata), .ram_wr(ram_wr), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .code_rd(code_rd), .code_addr(code_addr),
		.code_rdata(code_rdata), .code_valid(code_valid),
		.code_external(code_external), .external_access_pin(ext_pin_n),
		.program_busy_flag(busy), .core_idle(idle),
		.double_speed_select(dbl), .boot_jump_select(bj),
		.boot_address(boot), .oscillator_range(osc),
		.osc_range_forbidden(forb), .lock_level_bits(lock));
	task chk(input [15:0] got, input [15:0] exp);
	begin
		num_checks = num_checks + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task tally_and_finish;
	begin
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	// first edge lets the launch update land before busy is polled
	task wait_idle(output integer c);
	begin
		c = 0;
		@(posedge clk);
		while (busy !== 1'b0 && c < 200) begin
			@(posedge clk);
			c = c + 1;
		end
	end
	endtask
	task t_reset;
	begin
		u_cpu.rd(8'hD1, d);
		chk(d, 8'h00);
		u_cpu.rd(8'hD0, d);
		chk(d, 8'h00);
		chk(dbl, 1'b0);
		chk(boot, 16'hF400);
		chk(osc, 2'b11);
		chk(forb, 1'b0);
		chk(lock, 3'b000);
		$display("reset test done");
	end
	endtask
	task t_map;
	begin
		u_cpu.wr(8'hD1, 8'h08);
		u_cpu.xw(16'h0086, 8'h55);
		repeat (2) @(posedge clk);
		chk(nram, 0);
		u_cpu.wr(8'hD1, 8'h00);
		u_cpu.xw(16'h0200, 8'h66);
		repeat (2) @(posedge clk);
		chk(nram, 1);
		chk(ram_last[23:8], 16'h0200);
		chk(ram_last[7:0], 8'h66);
		$display("map test done");
	end
	endtask
	task t_prog;
	begin
		u_cpu.wr(8'hD1, 8'h08);
		u_cpu.xw(16'h0085, 8'h3C);
		u_cpu.launch(2'b00);
		@(posedge clk);
		chk(busy, 1'b1);
		chk(idle, 1'b1);
		u_cpu.rd(8'hD1, d);
		chk(d[0], 1'b1);
		u_cpu.wr(8'hD1, 8'h00);
		chk(busy, 1'b1);
		u_cpu.fetch(16'h0085, r);
		chk(r, 10'h1FF);
		wait_idle(n);
		chk(n < PC, 1'b1);
		u_cpu.fetch(16'h0085, r);
		chk(r, 10'h13C);
		u_cpu.fetch(16'h0086, r);
		chk(r, 10'h155);
		$display("program test done");
	end
	endtask
	task t_unlock;
	begin
		u_cpu.wr(8'hD1, 8'h50);
		u_cpu.wr(8'hD1, 8'h00);
		u_cpu.wr(8'hD1, 8'hA0);
		repeat (3) @(posedge clk);
		chk(busy, 1'b0);
		u_cpu.launch(2'b11);
		repeat (3) @(posedge clk);
		chk(busy, 1'b0);
		$display("unlock test done");
	end
	endtask
	task t_xrow;
	begin
		u_cpu.wr(8'hD1, 8'h08);
		u_cpu.xw(16'hFF81, 8'h5A);
		u_cpu.launch(2'b01);
		wait_idle(n);
		u_cpu.wr(8'hD1, 8'h02);
		u_cpu.fetch(16'hFF81, r);
		chk(r, 10'h15A);
		u_cpu.fetch(16'h0081, r);
		chk(r, 10'h1FF);
		u_cpu.wr(8'hD1, 8'h00);
		u_cpu.fetch(16'h0085, r);
		chk(r, 10'h13C);
		$display("extra row test done");
	end
	endtask
	task t_sec;
	begin
		u_cpu.wr(8'hD1, 8'h0C);
		u_cpu.xw(16'h0000, 8'h5F);
		u_cpu.launch(2'b10);
		wait_idle(n);
		u_cpu.wr(8'hD1, 8'h04);
		u_cpu.fetch(16'h0000, r);
		chk(r, 10'h150);
		chk(dbl, 1'b1);
		chk(osc, 2'b01);
		chk(lock, 3'b000);
		chk(boot, 16'hF400);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk(boot, 16'h0000);
		chk(bj, 1'b1);
		$display("security test done");
	end
	endtask
	task t_ext;
	begin
		ext_pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		u_cpu.fetch(16'h0085, r);
		chk(r, 10'h3FF);
		ext_pin_n <= 1'b1;
		$display("external test done");
	end
	endtask
	initial begin
		#400000;
		num_errors = num_errors + 1;
		tally_and_finish;
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		t_reset;
		t_map;
		t_prog;
		t_unlock;
		t_xrow;
		t_sec;
		t_ext;
		tally_and_finish;
	end
endmodule
